// ---- hdl/rcr_defs.svh ----
// Offsets, field positions, reset values and timing counts of the radio control registers
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RCR_ADDR_REVISION_INFO      6'h00
`define RCR_ADDR_RADIO_CONTROL      6'h03
`define RCR_ADDR_DATA_RATE          6'h04
`define RCR_ADDR_LOCK_COUNT         6'h38

// ****************************************************************
// Field positions
// ****************************************************************
`define RCR_BIT_RX_ENABLE           7
`define RCR_BIT_TX_ENABLE           6
`define RCR_BIT_CODE_HALF           5
`define RCR_BIT_LOCK_BYPASS         4
`define RCR_BIT_AMP_MANUAL          3
`define RCR_BIT_AMP_ON              2
`define RCR_BIT_CODE_WIDTH          2
`define RCR_CONTROL_WR_MASK         8'hFC

// ****************************************************************
// Reset values
// ****************************************************************
`define RCR_RADIO_CONTROL_RST       8'h00
`define RCR_DATA_RATE_RST           8'h00
`define RCR_LOCK_COUNT_RST          8'h64

// ****************************************************************
// Timing
// ****************************************************************
`define RCR_CLOCK_MHZ               250
`define RCR_LOCK_UNIT_US            2
`define RCR_LOCK_UNIT_CYCLES        (`RCR_LOCK_UNIT_US * `RCR_CLOCK_MHZ)

`endif

// ---- hdl/rcr_pkg.sv ----
// Types of the radio control registers
package rcr_pkg;
    typedef logic [7:0] rcr_byte_t;
    typedef enum logic [1:0] {
        RCR_SETTLE_IDLE,
        RCR_SETTLE_WAIT_LOCK,
        RCR_SETTLE_COUNT,
        RCR_SETTLE_DONE
    } rcr_settle_e;
endpackage : rcr_pkg

// ---- hdl/rcr_sync.sv ----
// Three flip-flop input synchroniser with agreement check
`timescale 1ns/100ps
`default_nettype none
module rcr_sync
(
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    input  wire logic i_async,
    output var  logic o_level
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic       level_q;
    logic       level_d;

    always_comb
    begin
        stage_d = {stage_q[1:0], i_async};
        level_d = (stage_q[2] == stage_q[1]) ? stage_q[1] : level_q;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            stage_q <= 3'h0;
            level_q <= 1'b0;
        end
        else
        begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign o_level = level_q;
endmodule : rcr_sync
`default_nettype wire

// ---- hdl/rcr_settle.sv ----
// Synthesizer settle sequencer: optional lock wait then lock count in 2 us units
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"
module rcr_settle
#(
    parameter int UNIT_CYCLES = `RCR_LOCK_UNIT_CYCLES
)
(
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_start,
    input  wire logic       i_bypass,
    input  wire logic       i_lock,
    input  wire logic [7:0] i_lock_count,
    output var  logic       o_settled
);
    rcr_pkg::rcr_settle_e state_q;
    rcr_pkg::rcr_settle_e state_d;
    logic [9:0]           unit_q;
    logic [9:0]           unit_d;
    logic [7:0]           count_q;
    logic [7:0]           count_d;
    logic                 settled_q;
    logic                 settled_d;

    always_comb
    begin
        state_d   = state_q;
        unit_d    = unit_q;
        count_d   = count_q;
        settled_d = 1'b0;
        if (!i_start)
        begin
            state_d = rcr_pkg::RCR_SETTLE_IDLE;
        end
        else
        begin
            unique case (state_q)
                rcr_pkg::RCR_SETTLE_IDLE:
                begin
                    unit_d  = 10'h000;
                    count_d = i_lock_count;
                    state_d = i_bypass ? rcr_pkg::RCR_SETTLE_COUNT        // R07
                                       : rcr_pkg::RCR_SETTLE_WAIT_LOCK;   // R08
                end
                rcr_pkg::RCR_SETTLE_WAIT_LOCK:
                begin
                    if (i_lock)                                           // R08
                    begin
                        state_d = rcr_pkg::RCR_SETTLE_COUNT;
                    end
                end
                rcr_pkg::RCR_SETTLE_COUNT:
                begin
                    if (count_q == 8'h00)
                    begin
                        state_d = rcr_pkg::RCR_SETTLE_DONE;
                    end
                    else if (unit_q == 10'(UNIT_CYCLES - 1))              // R07
                    begin
                        unit_d  = 10'h000;
                        count_d = count_q - 8'h01;
                    end
                    else
                    begin
                        unit_d = unit_q + 10'h001;
                    end
                end
                rcr_pkg::RCR_SETTLE_DONE:
                begin
                    settled_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_q   <= rcr_pkg::RCR_SETTLE_IDLE;
            unit_q    <= 10'h000;
            count_q   <= 8'h00;
            settled_q <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            unit_q    <= unit_d;
            count_q   <= count_d;
            settled_q <= settled_d;
        end
    end

    assign o_settled = settled_q;

    a_settle_early: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_q == rcr_pkg::RCR_SETTLE_WAIT_LOCK && !i_lock) |=> !settled_q) // R08
        else $error("settled before lock indication");
    a_bypass_path: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (state_q == rcr_pkg::RCR_SETTLE_IDLE && i_start && i_bypass)
        |=> state_q == rcr_pkg::RCR_SETTLE_COUNT) // R07
        else $error("bypass did not skip lock wait");
endmodule : rcr_settle
`default_nettype wire

// ---- hdl/rcr_regs.sv ----
// Revision and radio control registers behind the serial register port
//
// Summary of operation
// R01 - Revision upper nibble is read-only die revision, incremented per silicon spin.
// R02 - Revision lower nibble is a fixed read-only part code.
// R03 - Control bit 7 enables receive.
// R04 - Control bit 6 enables transmit.
// R05 - Control bit 5 picks upper or lower 32 chips of 64-chip code.
// R06 - Code-half choice matters only in 32-chip code width.
// R07 - Bit 4 set: skip lock indication, wait only lock count of 2 us units.
// R08 - Bit 4 clear: wait lock indication, then the lock count.
// R09 - Host should program lock count 25 when using lock indication.
// R10 - Host should set the lock bypass bit for consistent settling.
// R11 - Bit 3 selects firmware or baseband control of the amplifier.
// R12 - Host should leave amplifier control with the baseband.
// R13 - Bit 2 drives the amplifier only under firmware control.
// R14 - Host writes zero to control bits 1 and 0.
// R15 - Data-rate bit 2 selects 32-chip codes when 1, 64 when 0.
// R16 - Control reads back last written bits 7 to 2, with bits 1 and 0 reading zero; zero after reset.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"
module rcr_regs
#(
    parameter logic [3:0] DIE_REVISION = 4'h3,   // Arbitrary value
    parameter logic [3:0] PART_CODE    = 4'hA,   // Arbitrary value
    parameter int         UNIT_CYCLES  = `RCR_LOCK_UNIT_CYCLES
)
(
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_wr_en,
    input  wire logic       i_rd_en,
    input  wire logic [5:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_syn_lock,
    input  wire logic       i_baseband_amp_req,
    output logic      [7:0] o_rd_data,
    output logic            o_rx_enable,
    output logic            o_tx_enable,
    output logic            o_code_upper_half,
    output logic            o_code_32_chip,
    output logic            o_amp_on,
    output logic            o_synth_settled
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    rcr_pkg::rcr_byte_t control_q;
    rcr_pkg::rcr_byte_t control_d;
    rcr_pkg::rcr_byte_t data_rate_q;
    rcr_pkg::rcr_byte_t data_rate_d;
    rcr_pkg::rcr_byte_t lock_count_q;
    rcr_pkg::rcr_byte_t lock_count_d;
    rcr_pkg::rcr_byte_t rd_data_q;
    rcr_pkg::rcr_byte_t rd_data_d;
    logic               rx_q;
    logic               rx_d;
    logic               tx_q;
    logic               tx_d;
    logic               half_q;
    logic               half_d;
    logic               w32_q;
    logic               w32_d;
    logic               amp_q;
    logic               amp_d;
    logic               lock_sync;
    logic               settled;

    rcr_sync u_lock_sync
    (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_syn_lock),
        .o_level   (lock_sync)
    );

    rcr_settle #(.UNIT_CYCLES(UNIT_CYCLES)) u_settle
    (
        .i_clock      (i_clock),
        .i_sys_rst    (i_sys_rst),
        .i_start      (control_q[`RCR_BIT_RX_ENABLE] | control_q[`RCR_BIT_TX_ENABLE]),
        .i_bypass     (control_q[`RCR_BIT_LOCK_BYPASS]),
        .i_lock       (lock_sync),
        .i_lock_count (lock_count_q),
        .o_settled    (settled)
    );

    // ****************************************************************
    // Writes and read mux
    // ****************************************************************
    always_comb
    begin
        control_d    = control_q;
        data_rate_d  = data_rate_q;
        lock_count_d = lock_count_q;
        rd_data_d    = rd_data_q;
        if (i_wr_en)
        begin
            unique case (i_addr)
                `RCR_ADDR_RADIO_CONTROL: control_d = i_wr_data & `RCR_CONTROL_WR_MASK; // R16
                `RCR_ADDR_DATA_RATE:     data_rate_d = i_wr_data;
                `RCR_ADDR_LOCK_COUNT:    lock_count_d = i_wr_data;
                default:                 control_d = control_q; // R01 R02
            endcase
        end
        if (i_rd_en)
        begin
            unique case (i_addr)
                `RCR_ADDR_REVISION_INFO: rd_data_d = {DIE_REVISION, PART_CODE}; // R01 R02
                `RCR_ADDR_RADIO_CONTROL: rd_data_d = control_q;                 // R16
                `RCR_ADDR_DATA_RATE:     rd_data_d = data_rate_q;
                `RCR_ADDR_LOCK_COUNT:    rd_data_d = lock_count_q;
                default:                 rd_data_d = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Radio controls
    // ****************************************************************
    always_comb
    begin
        rx_d   = control_q[`RCR_BIT_RX_ENABLE];                                 // R03
        tx_d   = control_q[`RCR_BIT_TX_ENABLE];                                 // R04
        w32_d  = data_rate_q[`RCR_BIT_CODE_WIDTH];                              // R15
        half_d = w32_d & control_q[`RCR_BIT_CODE_HALF];                        // R05 R06
        amp_d  = control_q[`RCR_BIT_AMP_MANUAL] ? control_q[`RCR_BIT_AMP_ON]   // R11 R13
                                                : (i_baseband_amp_req & settled);
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            control_q    <= `RCR_RADIO_CONTROL_RST;
            data_rate_q  <= `RCR_DATA_RATE_RST;
            lock_count_q <= `RCR_LOCK_COUNT_RST;
            rd_data_q    <= 8'h00;
            rx_q         <= 1'b0;
            tx_q         <= 1'b0;
            half_q       <= 1'b0;
            w32_q        <= 1'b0;
            amp_q        <= 1'b0;
        end
        else
        begin
            control_q    <= control_d;
            data_rate_q  <= data_rate_d;
            lock_count_q <= lock_count_d;
            rd_data_q    <= rd_data_d;
            rx_q         <= rx_d;
            tx_q         <= tx_d;
            half_q       <= half_d;
            w32_q        <= w32_d;
            amp_q        <= amp_d;
        end
    end

    logic settled_q;
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            settled_q <= 1'b0;
        end
        else
        begin
            settled_q <= settled;
        end
    end

    assign o_rd_data         = rd_data_q;
    assign o_rx_enable       = rx_q;
    assign o_tx_enable       = tx_q;
    assign o_code_upper_half = half_q;
    assign o_code_32_chip    = w32_q;
    assign o_amp_on          = amp_q;
    assign o_synth_settled   = settled_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_rev_read: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_rd_en && i_addr == `RCR_ADDR_REVISION_INFO)
        |=> o_rd_data == {DIE_REVISION, PART_CODE}) // R01
        else $error("revision read wrong");
    a_part_fixed: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_rd_en && i_addr == `RCR_ADDR_REVISION_INFO) |=> o_rd_data[3:0] == PART_CODE) // R02
        else $error("part code changed");
    a_rx_follow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_wr_en && i_addr == `RCR_ADDR_RADIO_CONTROL)
        |=> ##1 o_rx_enable == $past(i_wr_data[7], 2)) // R03
        else $error("receive enable wrong");
    a_tx_follow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_wr_en && i_addr == `RCR_ADDR_RADIO_CONTROL)
        |=> ##1 o_tx_enable == $past(i_wr_data[6], 2)) // R04
        else $error("transmit enable wrong");
    a_half_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !o_code_32_chip |-> !o_code_upper_half) // R06
        else $error("code half used in 64-chip mode");
    a_half_sel: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (data_rate_q[2] && control_q[5]) |=> o_code_upper_half) // R05
        else $error("code half not selected");
    a_amp_manual: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        control_q[3] |=> o_amp_on == $past(control_q[2])) // R13
        else $error("manual amplifier wrong");
    a_amp_auto: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (!control_q[3] && !i_baseband_amp_req) |=> !o_amp_on) // R11
        else $error("auto amplifier wrong");
    a_ctrl_back: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_wr_en && i_addr == `RCR_ADDR_RADIO_CONTROL)
        |=> control_q == ($past(i_wr_data) & 8'hFC)) // R16
        else $error("control readback wrong");
    a_width_sel: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        ##1 o_code_32_chip == $past(data_rate_q[2])) // R15
        else $error("code width wrong");
endmodule : rcr_regs
`default_nettype wire

// ---- tb/rcr_host_model.sv ----
// Host microcontroller model driving the register port
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"
module rcr_host_model
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rd_data,
    output var  logic       o_wr_en,
    output var  logic       o_rd_en,
    output var  logic [5:0] o_addr,
    output var  logic [7:0] o_wr_data
);
    initial
    begin
        o_wr_en   = 1'b0;
        o_rd_en   = 1'b0;
        o_addr    = 6'h2A;
        o_wr_data = 8'h55;
    end

    // ****************************************************************
    // One-byte write, lines inverted once released
    // ****************************************************************
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = (a == `RCR_ADDR_RADIO_CONTROL) ? (d & `RCR_CONTROL_WR_MASK) : d;
        @(posedge i_clock);
        o_addr    <= a;
        o_wr_data <= v;
        o_wr_en   <= 1'b1;
        @(posedge i_clock);
        o_wr_en   <= 1'b0;
        o_addr    <= ~a;
        o_wr_data <= ~v;
    endtask : wr

    // ****************************************************************
    // One-byte read, data taken one cycle after the strobe edge
    // ****************************************************************
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_addr  <= a;
        o_rd_en <= 1'b1;
        @(posedge i_clock);
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        @(posedge i_clock);
        #1;
        d = i_rd_data;
    endtask : rd
endmodule : rcr_host_model
`default_nettype wire

// ---- tb/tb_radio_control_and_revision_regs.sv ----
// Self-checking bench of the revision and radio control registers
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"
module tb_radio_control_and_revision_regs;
    logic       i_clock = 1'b0;
    logic       i_sys_rst = 1'b1;
    logic       i_syn_lock = 1'b0;
    logic       i_baseband_amp_req = 1'b0;
    logic       wr_en;
    logic       rd_en;
    logic [5:0] addr;
    logic [7:0] wr_data;
    logic [7:0] o_rd_data;
    logic       o_rx_enable;
    logic       o_tx_enable;
    logic       o_code_upper_half;
    logic       o_code_32_chip;
    logic       o_amp_on;
    logic       o_synth_settled;
    logic [7:0] rv;
    int         miscompares = 0;
    int         tests_run = 0;
    int         cycles = 0;

    always #2 i_clock = ~i_clock;

    rcr_host_model host (.i_clock(i_clock), .i_rd_data(o_rd_data), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));

    rcr_regs #(.UNIT_CYCLES(4)) dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data),
        .i_syn_lock(i_syn_lock), .i_baseband_amp_req(i_baseband_amp_req),
        .o_rd_data(o_rd_data), .o_rx_enable(o_rx_enable), .o_tx_enable(o_tx_enable),
        .o_code_upper_half(o_code_upper_half), .o_code_32_chip(o_code_32_chip),
        .o_amp_on(o_amp_on), .o_synth_settled(o_synth_settled));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wr_ctl(input logic [7:0] d);
        host.wr(`RCR_ADDR_RADIO_CONTROL, d);
        repeat (3) @(posedge i_clock);
        #1;
    endtask : wr_ctl

    // Cycles until settled, bounded by hi
    task automatic time_settle(input int lo, input int hi, input string msg);
        int n;
        n = 0;
        while (o_synth_settled !== 1'b1 && n < hi)
        begin
            @(posedge i_clock);
            #1;
            n++;
        end
        check({7'h00, (n >= lo && n < hi)}, 8'h01, msg);
    endtask : time_settle

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset_and_revision();
        host.rd(`RCR_ADDR_RADIO_CONTROL, rv);
        check(rv, `RCR_RADIO_CONTROL_RST, "control after reset");
        check({o_rx_enable, o_tx_enable, o_amp_on, o_synth_settled}, 8'h00, "outputs idle");
        host.wr(`RCR_ADDR_REVISION_INFO, 8'hF5);
        host.rd(`RCR_ADDR_REVISION_INFO, rv);
        check(rv, 8'h3A, "revision after write");
        host.rd(6'h10, rv);
        check(rv, 8'h00, "unmapped read");
        $display("test_reset_and_revision done");
    endtask : test_reset_and_revision

    task automatic test_rx_tx();
        logic [7:0] tab [4];
        tab = '{8'hC0, 8'h80, 8'h40, 8'h00};
        foreach (tab[i])
        begin
            wr_ctl(tab[i] | 8'h03);
            check({7'h00, o_rx_enable}, {7'h00, tab[i][7]}, "rx enable");
            check({7'h00, o_tx_enable}, {7'h00, tab[i][6]}, "tx enable");
            host.rd(`RCR_ADDR_RADIO_CONTROL, rv);
            check(rv, tab[i], "control readback");
        end
        $display("test_rx_tx done");
    endtask : test_rx_tx

    task automatic test_code_half();
        host.wr(`RCR_ADDR_DATA_RATE, 8'h00);
        wr_ctl(8'h20);
        check({o_code_32_chip, o_code_upper_half}, 8'h00, "64-chip ignores half");
        host.wr(`RCR_ADDR_DATA_RATE, 8'h04);
        repeat (3) @(posedge i_clock);
        #1;
        check({o_code_32_chip, o_code_upper_half}, 8'h03, "32-chip upper half");
        wr_ctl(8'h00);
        check({o_code_32_chip, o_code_upper_half}, 8'h02, "32-chip lower half");
        $display("test_code_half done");
    endtask : test_code_half

    task automatic test_amp_manual();
        i_baseband_amp_req <= 1'b1;
        wr_ctl(8'h08);
        check({7'h00, o_amp_on}, 8'h00, "manual off ignores baseband");
        wr_ctl(8'h0C);
        check({7'h00, o_amp_on}, 8'h01, "manual on");
        wr_ctl(8'h04);
        check({7'h00, o_amp_on}, 8'h00, "auto ignores bit 2 while unsettled");
        i_baseband_amp_req <= 1'b0;
        $display("test_amp_manual done");
    endtask : test_amp_manual

    task automatic test_settle_bypass();
        host.wr(`RCR_ADDR_LOCK_COUNT, 8'h03);
        wr_ctl(8'h90);
        time_settle(10, 24, "bypass settle time without lock");
        wr_ctl(8'h00);
        check({7'h00, o_synth_settled}, 8'h00, "settled drops when idle");
        $display("test_settle_bypass done");
    endtask : test_settle_bypass

    task automatic test_settle_lock();
        host.wr(`RCR_ADDR_LOCK_COUNT, 8'd25);
        wr_ctl(8'h80);
        repeat (60) @(posedge i_clock);
        #1;
        check({7'h00, o_synth_settled}, 8'h00, "waits for lock");
        i_syn_lock <= 1'b1;
        time_settle(98, 125, "lock then count");
        i_baseband_amp_req <= 1'b1;
        repeat (3) @(posedge i_clock);
        #1;
        check({7'h00, o_amp_on}, 8'h01, "auto amplifier follows baseband");
        i_baseband_amp_req <= 1'b0;
        repeat (3) @(posedge i_clock);
        #1;
        check({7'h00, o_amp_on}, 8'h00, "auto amplifier released");
        $display("test_settle_lock done");
    endtask : test_settle_lock

    initial
    begin
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        test_reset_and_revision();
        test_rx_tx();
        test_code_half();
        test_amp_manual();
        test_settle_bypass();
        test_settle_lock();
        report_and_stop();
    end
endmodule : tb_radio_control_and_revision_regs
`default_nettype wire
